/* inc/tfs_pkg.sv */
// constants and types shared by the test frame source
package tfs_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0]  IDX_CTRL     = 8'h1d;
   localparam logic [7:0]  IDX_PAYLOAD  = 8'h1e;
   localparam logic [7:0]  IDX_ERRCNT   = 8'h17;
   localparam logic [7:0]  IDX_STATUS   = 8'h18;
   // control field positions
   localparam int          B_EN         = 15;
   localparam int          B_RUN        = 14;
   localparam int          B_CONT       = 13;
   localparam int          B_LEN        = 11;
   localparam int          B_IPG        = 10;
   localparam int          B_DA         = 6;
   localparam int          B_SA         = 2;
   localparam int          B_RAND       = 1;
   localparam int          B_BADFCS     = 0;
   // reset values
   localparam logic [15:0] CTRL_RST     = 16'h0040;
   localparam logic [15:0] PAYLOAD_RST  = 16'h0000;
   localparam logic [15:0] LFSR_SEED    = 16'hace1;
   // frame layout in bytes
   localparam logic [13:0] LEN_125      = 14'd125;
   localparam logic [13:0] LEN_64       = 14'd64;
   localparam logic [13:0] LEN_1518     = 14'd1518;
   localparam logic [13:0] HDR_LEN      = 14'd14;
   localparam logic [13:0] FCS_LEN      = 14'd4;
   localparam logic [13:0] LENFIELD_SUB = 14'd18;
   localparam logic [43:0] ADDR_HIGH    = 44'hfff_ffff_ffff;
   // frame check sequence
   localparam logic [31:0] CRC_INIT     = 32'hffff_ffff;
   localparam logic [31:0] CRC_POLY     = 32'hedb8_8320;
   localparam logic [31:0] CRC_RESIDUE  = 32'hdebb_20e3;
   // timing
   localparam int          CLK_NS       = 25;
   localparam int          IPG_SHORT_NS = 96;
   localparam int          IPG_LONG_NS  = 8192;
   localparam logic [9:0]  IPG_SHORT_CYC = 10'((IPG_SHORT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0]  IPG_LONG_CYC  = 10'((IPG_LONG_NS + CLK_NS - 1) / CLK_NS);
   typedef enum logic [1:0] {TFS_IDLE, TFS_FRAME, TFS_GAP} tfs_state_t;
endpackage

/* logic/tfs_fifo.sv */
// byte fifo with registered output stage between generator and link
`timescale 1ns/1ps
module tfs_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  logic             clk,
   input  logic             nrst,
   input  logic [WIDTH-1:0] in_data,
   input  logic             in_valid,
   output logic             in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic             out_valid,
   input  logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic [CW-1:0]    count;
   logic             push;
   logic             pop;

   assign in_ready = count != CW'(DEPTH);
   assign push     = in_valid && in_ready;
   assign pop      = (count != '0) && (!out_valid || out_ready);

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wptr] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         wptr      <= '0;
         rptr      <= '0;
         count     <= '0;
         out_data  <= '0;
         out_valid <= 1'b0;
      end
      else
      begin
         if (push)
            wptr <= AW'(wptr + 1'b1);
         if (pop)
         begin
            rptr     <= AW'(rptr + 1'b1);
            out_data <= mem[rptr];
         end
         out_valid <= pop || (out_valid && !out_ready);
         count     <= CW'(count + CW'(push) - CW'(pop));
      end
   end
endmodule

/* logic/tfs_packet_source.sv */
// test frame source: apb registers, frame builder, output fifo
`timescale 1ns/1ps
module tfs_packet_source #(
   parameter int          BATCH_PKTS = 30000000,
   parameter int          BLOCK_PKTS = 10000,
   parameter logic [13:0] JUMBO_LEN  = 14'd10000,
   parameter int          FIFO_DEPTH = 16
) (
   input  logic        clk,
   input  logic        nrst,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [11:0] paddr,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   input  logic        crc_err_in,
   output logic [7:0]  tx_data,
   output logic        tx_last,
   output logic        tx_valid,
   input  logic        tx_ready
);
   function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h0, d};
      for (int i = 0; i < 8; i++)
         r = r[0] ? ((r >> 1) ^ tfs_pkg::CRC_POLY) : (r >> 1);
      return r;
   endfunction

   function automatic logic [7:0] addr_byte(input logic [47:0] a, input logic [13:0] i);
      logic [47:0] s;
      s = a << {i[2:0], 3'b000};
      return s[47:40];
   endfunction

   // register bus decode
   logic        acc;
   logic        done;
   logic        wr;
   logic        aligned;
   logic [7:0]  idx_bus;
   logic        hit_ctrl;
   logic        hit_pay;
   logic        hit_err;
   logic        hit_stat;
   logic        mapped;
   logic        rd_err;
   logic [31:0] rd_mux;

   logic [15:0] ctrl;
   logic [15:0] payload;
   logic [13:0] act;
   logic [15:0] act_pat;
   logic [7:0]  errcnt;
   logic [7:0]  next_errcnt;
   logic        pend;
   logic        start_wr;
   logic        batch_done;

   assign acc      = psel && penable;
   assign done     = acc && pready;
   assign wr       = done && pwrite;
   assign aligned  = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
   assign idx_bus  = paddr[9:2];
   assign hit_ctrl = aligned && idx_bus == tfs_pkg::IDX_CTRL;
   assign hit_pay  = aligned && idx_bus == tfs_pkg::IDX_PAYLOAD;
   assign hit_err  = aligned && idx_bus == tfs_pkg::IDX_ERRCNT;
   assign hit_stat = aligned && idx_bus == tfs_pkg::IDX_STATUS;
   assign mapped   = hit_ctrl || hit_pay || hit_err || hit_stat;
   assign rd_err   = done && !pwrite && hit_err;
   assign start_wr = wr && hit_ctrl && pwdata[tfs_pkg::B_EN] && pwdata[tfs_pkg::B_RUN]
                     && !ctrl[tfs_pkg::B_RUN];

   tfs_pkg::tfs_state_t state;
   tfs_pkg::tfs_state_t next_state;

   always_comb
   begin
      if (hit_ctrl)
         rd_mux = {16'h0, ctrl};
      else if (hit_pay)
         rd_mux = {16'h0, payload};
      else if (hit_err)
         rd_mux = {24'h0, errcnt};
      else if (hit_stat)
         rd_mux = {30'h0, batch_done, state != tfs_pkg::TFS_IDLE};
      else
         rd_mux = 32'h0;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= acc && !pready;
         prdata  <= (acc && !pready && !pwrite) ? rd_mux : 32'h0;
         pslverr <= acc && !pready && !mapped;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ctrl    <= tfs_pkg::CTRL_RST;
         payload <= tfs_pkg::PAYLOAD_RST;
      end
      else
      begin
         if (wr && hit_ctrl)
            ctrl <= pwdata[15:0];
         if (wr && hit_pay)
            payload <= pwdata[15:0];
      end
   end

   // error counter: an event in the read cycle survives as a count of one
   assign next_errcnt = crc_err_in ? (rd_err ? 8'h01
                                             : (errcnt == 8'hff ? 8'hff : 8'(errcnt + 8'h01)))
                                   : (rd_err ? 8'h00 : errcnt);

   always_ff @(posedge clk)
   begin
      if (!nrst)
         errcnt <= 8'h00;
      else
         errcnt <= next_errcnt;
   end

   // active settings and frame fields
   logic [13:0] frame_len;
   logic [13:0] data_end;
   logic [47:0] da_addr;
   logic [47:0] sa_addr;
   logic [15:0] len_field;
   logic [13:0] idx;
   logic [31:0] crc;
   logic [31:0] fcs_word;
   logic [1:0]  fcs_k;
   logic [15:0] lfsr;
   logic [7:0]  byte_out;
   logic        push_valid;
   logic        fifo_ready;
   logic        accept;
   logic        last;
   logic        in_pay;
   logic [9:0]  gap_cnt;
   logic        halt;
   logic        halt_now;
   logic        batch_hit;
   logic        blk_hit;
   logic [31:0] pkt_cnt;
   logic [31:0] blk_cnt;

   assign frame_len = act[12:11] == 2'b00 ? tfs_pkg::LEN_125 :
                      act[12:11] == 2'b01 ? tfs_pkg::LEN_64 :
                      act[12:11] == 2'b10 ? tfs_pkg::LEN_1518 : JUMBO_LEN;
   assign data_end  = frame_len - tfs_pkg::FCS_LEN;
   assign da_addr   = {tfs_pkg::ADDR_HIGH, act[9:6]};
   assign sa_addr   = {tfs_pkg::ADDR_HIGH, act[5:2]};
   assign len_field = {2'b00, 14'(frame_len - tfs_pkg::LENFIELD_SUB)};
   assign fcs_word  = act[tfs_pkg::B_BADFCS] ? crc : ~crc;
   assign fcs_k     = 2'(idx - data_end);
   assign in_pay    = idx >= tfs_pkg::HDR_LEN && idx < data_end;
   assign push_valid = state == tfs_pkg::TFS_FRAME;
   assign accept    = push_valid && fifo_ready;
   assign last      = idx == frame_len - 14'd1;

   always_comb
   begin
      if (idx < 14'd6)
         byte_out = addr_byte(da_addr, idx);
      else if (idx < 14'd12)
         byte_out = addr_byte(sa_addr, 14'(idx - 14'd6));
      else if (idx == 14'd12)
         byte_out = len_field[15:8];
      else if (idx == 14'd13)
         byte_out = len_field[7:0];
      else if (in_pay && act[tfs_pkg::B_RAND])
         byte_out = lfsr[7:0];
      else if (in_pay)
         byte_out = idx[0] ? act_pat[7:0] : act_pat[15:8];
      else
         byte_out = fcs_word[{fcs_k, 3'b000} +: 8];
   end

   // stop decisions taken as the last byte of a frame is accepted
   assign batch_hit = !act[tfs_pkg::B_CONT] && pkt_cnt == 32'(BATCH_PKTS - 1);
   assign blk_hit   = act[tfs_pkg::B_CONT] && !ctrl[tfs_pkg::B_CONT]
                      && blk_cnt == 32'(BLOCK_PKTS - 1);
   assign halt_now  = batch_hit || blk_hit || pend
                      || !(ctrl[tfs_pkg::B_EN] && ctrl[tfs_pkg::B_RUN]);

   always_comb
   begin
      next_state = state;
      case (state)
         tfs_pkg::TFS_IDLE:
            if (pend)
               next_state = tfs_pkg::TFS_FRAME;
         tfs_pkg::TFS_FRAME:
            if (accept && last)
               next_state = tfs_pkg::TFS_GAP;
         default:
            if (gap_cnt == 10'd0)
               next_state = halt ? tfs_pkg::TFS_IDLE : tfs_pkg::TFS_FRAME;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state      <= tfs_pkg::TFS_IDLE;
         pend       <= 1'b0;
         act        <= tfs_pkg::CTRL_RST[13:0];
         act_pat    <= tfs_pkg::PAYLOAD_RST;
         idx        <= 14'd0;
         crc        <= tfs_pkg::CRC_INIT;
         lfsr       <= tfs_pkg::LFSR_SEED;
         gap_cnt    <= 10'd0;
         halt       <= 1'b0;
         pkt_cnt    <= 32'd0;
         blk_cnt    <= 32'd0;
         batch_done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (start_wr)
            pend <= 1'b1;
         else if (wr && hit_ctrl && !(pwdata[tfs_pkg::B_EN] && pwdata[tfs_pkg::B_RUN]))
            pend <= 1'b0;
         else if (state == tfs_pkg::TFS_IDLE)
            pend <= 1'b0;
         if (state == tfs_pkg::TFS_IDLE && pend)
         begin
            act        <= ctrl[13:0];
            act_pat    <= payload;
            pkt_cnt    <= 32'd0;
            blk_cnt    <= 32'd0;
            batch_done <= 1'b0;
            idx        <= 14'd0;
            crc        <= tfs_pkg::CRC_INIT;
            lfsr       <= tfs_pkg::LFSR_SEED;
         end
         if (accept)
         begin
            idx <= last ? 14'd0 : 14'(idx + 14'd1);
            if (idx < data_end)
               crc <= crc_upd(crc, byte_out);
            else if (last)
               crc <= tfs_pkg::CRC_INIT;
            if (in_pay && act[tfs_pkg::B_RAND])
               lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         end
         if (accept && last)
         begin
            gap_cnt <= (act[tfs_pkg::B_IPG] ? tfs_pkg::IPG_LONG_CYC
                                            : tfs_pkg::IPG_SHORT_CYC) - 10'd1;
            halt    <= halt_now;
            pkt_cnt <= 32'(pkt_cnt + 32'd1);
            blk_cnt <= blk_cnt == 32'(BLOCK_PKTS - 1) ? 32'd0 : 32'(blk_cnt + 32'd1);
            if (batch_hit)
               batch_done <= 1'b1;
         end
         else if (state == tfs_pkg::TFS_GAP && gap_cnt != 10'd0)
            gap_cnt <= 10'(gap_cnt - 10'd1);
      end
   end

   tfs_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_data   ({last, byte_out}),
      .in_valid  (push_valid),
      .in_ready  (fifo_ready),
      .out_data  ({tx_last, tx_data}),
      .out_valid (tx_valid),
      .out_ready (tx_ready)
   );

   // checking helpers
   logic [31:0] res;
   logic [31:0] res_next;
   logic [9:0]  idle_run;
   logic [7:0]  last_pushed;

   assign res_next = crc_upd(res, byte_out);

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         res         <= tfs_pkg::CRC_INIT;
         idle_run    <= 10'd0;
         last_pushed <= 8'h00;
      end
      else
      begin
         // byte actually handed to the fifo, so a stall does not repeat it
         if (accept)
         begin
            res         <= last ? tfs_pkg::CRC_INIT : res_next;
            last_pushed <= byte_out;
         end
         idle_run <= push_valid ? 10'd0 : (idle_run == 10'h3ff ? idle_run : 10'(idle_run + 10'd1));
      end
   end

   sequence s_frame_end;
      accept && last;
   endsequence

   sequence s_short_gap;
      !push_valid [*4];
   endsequence

   chk_start_cause: assert property (@(posedge clk) disable iff (!nrst)
      $rose(push_valid) && pkt_cnt == 32'd0 |-> $past(pend) && ctrl[15] && ctrl[14])
      else $error("generator started without run and enable");

   chk_frame_length: assert property (@(posedge clk) disable iff (!nrst)
      s_frame_end |-> idx == frame_len - 14'd1 && (frame_len == tfs_pkg::LEN_125
      || frame_len == tfs_pkg::LEN_64 || frame_len == tfs_pkg::LEN_1518 || frame_len == JUMBO_LEN))
      else $error("frame length wrong");

   chk_gap_short: assert property (@(posedge clk) disable iff (!nrst)
      (s_frame_end and !act[tfs_pkg::B_IPG]) |=> s_short_gap)
      else $error("short gap too short");

   chk_gap_length: assert property (@(posedge clk) disable iff (!nrst)
      $rose(push_valid) && pkt_cnt != 32'd0 |-> idle_run == (act[tfs_pkg::B_IPG]
      ? tfs_pkg::IPG_LONG_CYC : tfs_pkg::IPG_SHORT_CYC))
      else $error("inter frame gap wrong");

   chk_addr_nibbles: assert property (@(posedge clk) disable iff (!nrst)
      accept && (idx == 14'd5 || idx == 14'd11) |-> byte_out == {4'hf,
      (idx == 14'd5 ? act[9:6] : act[5:2])})
      else $error("address low nibble wrong");

   chk_fixed_payload: assert property (@(posedge clk) disable iff (!nrst)
      accept && in_pay && !act[tfs_pkg::B_RAND] && idx[0] |->
      byte_out == act_pat[7:0] && last_pushed == act_pat[15:8])
      else $error("fixed payload wrong");

   chk_fcs_residue: assert property (@(posedge clk) disable iff (!nrst)
      s_frame_end |-> (res_next == tfs_pkg::CRC_RESIDUE) == !act[tfs_pkg::B_BADFCS])
      else $error("frame check sequence wrong");

   chk_cfg_hold: assert property (@(posedge clk) disable iff (!nrst)
      state != tfs_pkg::TFS_IDLE && $past(state) != tfs_pkg::TFS_IDLE |-> $stable(act)
      && $stable(act_pat))
      else $error("settings changed while running");

   chk_batch_stop: assert property (@(posedge clk) disable iff (!nrst)
      (s_frame_end and batch_hit) |=> state == tfs_pkg::TFS_GAP && halt && batch_done)
      else $error("batch did not stop");

   chk_err_saturate: assert property (@(posedge clk) disable iff (!nrst)
      errcnt == 8'hff && !rd_err |=> errcnt == 8'hff)
      else $error("error counter wrapped");

   chk_err_rdclear: assert property (@(posedge clk) disable iff (!nrst)
      rd_err |=> errcnt == {7'h0, $past(crc_err_in)})
      else $error("error counter not cleared by read");
endmodule

/* tb/tfs_link_sink.sv */
// link partner model: takes frame bytes, may stall, keeps the last frame
`timescale 1ns/1ps
module tfs_link_sink (
   input  logic       clk,
   input  logic       nrst,
   input  logic [7:0] tx_data,
   input  logic       tx_last,
   input  logic       tx_valid,
   input  logic       slow,
   output logic       tx_ready,
   output int         frames,
   output int         len,
   output int         gap
);
   logic [7:0]  mem [0:2047];
   logic [15:0] lfsr;
   int          idx;
   int          since;
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         lfsr <= 16'h0001;
         tx_ready <= 1'b0;
         frames <= 0;
         len <= 0;
         gap <= 0;
         idx <= 0;
         since <= 0;
      end
      else
      begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         tx_ready <= slow ? lfsr[0] : 1'b1;
         since <= since + 1;
         if (tx_valid && tx_ready)
         begin
            mem[idx] <= tx_data;
            idx <= idx + 1;
            if (idx == 0)
               gap <= since;
            if (tx_last)
            begin
               len <= idx + 1;
               frames <= frames + 1;
               idx <= 0;
               since <= 0;
            end
         end
      end
   end
endmodule

/* tb/tfs_packet_source_bench.sv */
// self-checking bench for the test frame source
`timescale 1ns/1ps
module tfs_packet_source_bench;
   localparam int          BATCH = 3;
   localparam int          BLOCK = 2;
   localparam logic [13:0] JUMBO = 14'd100;
   logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, crc_err_in = 0, slow = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r, rd, seed = 32'd67;
   logic        pready, pslverr, tx_last, tx_valid, tx_ready, err;
   logic [7:0]  tx_data;
   int          frames, len, gap, mismatches = 0, n_compared = 0, i, n, f0;
   always #12.5 clk = ~clk;
   tfs_packet_source #(.BATCH_PKTS(BATCH), .BLOCK_PKTS(BLOCK), .JUMBO_LEN(JUMBO),
      .FIFO_DEPTH(16)) dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .crc_err_in(crc_err_in), .tx_data(tx_data), .tx_last(tx_last),
      .tx_valid(tx_valid), .tx_ready(tx_ready));
   // isolated partner, never a live network
   tfs_link_sink sink_u (.clk(clk), .nrst(nrst), .tx_data(tx_data), .tx_last(tx_last),
      .tx_valid(tx_valid), .slow(slow), .tx_ready(tx_ready), .frames(frames), .len(len),
      .gap(gap));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [13:0] len_of(input logic [1:0] c);
      return (c == 2'd0) ? tfs_pkg::LEN_125 : (c == 2'd1) ? tfs_pkg::LEN_64 :
         (c == 2'd2) ? tfs_pkg::LEN_1518 : JUMBO;
   endfunction
   function automatic logic [31:0] crc(input int nb);
      logic [31:0] c;
      c = tfs_pkg::CRC_INIT;
      for (int k = 0; k < nb; k++)
      begin
         c ^= {24'h0, sink_u.mem[k]};
         for (int b = 0; b < 8; b++)
            c = c[0] ? ((c >> 1) ^ tfs_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic cut();
      check(32'h0, 32'h1);
      conclude();
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int t;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      t = 0;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (pready !== 1'b1 && t < 50);
      if (t >= 50)
         cut();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic poll_status(input int b, input logic v);
      int t;
      t = 0;
      do
      begin
         apb(1'b0, tfs_pkg::IDX_STATUS, 32'h0);
         t++;
      end
      while (rd[b] !== v && t < 5000);
      if (t >= 5000)
         cut();
   endtask
   task automatic wait_frames(input int target);
      int t;
      for (t = 0; frames < target && t < 20000; t++)
         @(posedge clk);
      if (frames < target)
         cut();
   endtask
   task automatic check_frame(input logic [1:0] lc, input logic [3:0] da, input logic [3:0] sa,
      input logic [15:0] pat, input logic rp, input logic bad);
      logic [13:0] l;
      logic [31:0] c;
      int          d;
      l = len_of(lc);
      d = 0;
      check(len, l);
      for (int k = 0; k < 6; k++)
      begin
         check(sink_u.mem[k], (k == 5) ? {4'hf, da} : 8'hff);
         check(sink_u.mem[k + 6], (k == 5) ? {4'hf, sa} : 8'hff);
      end
      check({sink_u.mem[12], sink_u.mem[13]}, l - tfs_pkg::LENFIELD_SUB);
      for (int k = 14; k < l - 4; k++)
      begin
         if (rp)
            d += (sink_u.mem[k] !== (k[0] ? pat[7:0] : pat[15:8]));
         else
            check(sink_u.mem[k], k[0] ? pat[7:0] : pat[15:8]);
      end
      if (rp)
         check(d > 0, 1'b1);
      c = crc(l - 4);
      check({sink_u.mem[l-1], sink_u.mem[l-2], sink_u.mem[l-3], sink_u.mem[l-4]},
         bad ? c : ~c);
   endtask
   task automatic batch(input logic [1:0] lc, input logic [3:0] da, input logic [3:0] sa,
      input logic [15:0] pat, input logic rp, input logic bad, input logic gp);
      logic [9:0] cy;
      cy = gp ? tfs_pkg::IPG_LONG_CYC : tfs_pkg::IPG_SHORT_CYC;
      f0 = frames;
      apb(1'b1, tfs_pkg::IDX_PAYLOAD, {16'h0, pat});
      apb(1'b1, tfs_pkg::IDX_CTRL, {16'h0, 3'b110, lc, gp, da, sa, rp, bad});
      poll_status(1, 1'b1);
      repeat (400) @(posedge clk);
      check(frames - f0, BATCH);
      check_frame(lc, da, sa, pat, rp, bad);
      if (!slow)
         check(gap >= cy - 1 && gap <= cy + 4, 1'b1);
      apb(1'b1, tfs_pkg::IDX_CTRL, {16'h0, 3'b100, lc, gp, da, sa, rp, bad});
      $display("batch of length code %0d done", lc);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      apb(1'b0, tfs_pkg::IDX_CTRL, 32'h0);
      check(rd, {16'h0, tfs_pkg::CTRL_RST});
      apb(1'b0, tfs_pkg::IDX_PAYLOAD, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h05, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      f0 = frames;
      apb(1'b1, tfs_pkg::IDX_CTRL, 32'h8000);
      apb(1'b1, tfs_pkg::IDX_CTRL, 32'h4000);
      apb(1'b1, tfs_pkg::IDX_CTRL, 32'hc000);
      repeat (200) @(posedge clk);
      check(frames - f0, 0);
      apb(1'b1, tfs_pkg::IDX_CTRL, 32'h0);
      for (i = 0; i < 4; i++)
      begin
         r = rnd();
         apb(1'b1, tfs_pkg::IDX_CTRL, {18'h0, r[13:0]});
         apb(1'b0, tfs_pkg::IDX_CTRL, 32'h0);
         check(rd, {18'h0, r[13:0]});
         apb(1'b1, tfs_pkg::IDX_PAYLOAD, {16'h0, r[31:16]});
         apb(1'b0, tfs_pkg::IDX_PAYLOAD, 32'h0);
         check(rd, {16'h0, r[31:16]});
      end
      apb(1'b1, tfs_pkg::IDX_CTRL, 32'h0);
      $display("register test done");
      for (i = 0; i < 8; i++)
      begin
         r = rnd();
         slow <= i[0];
         batch(i[1:0], r[3:0], r[7:4], r[23:8], i == 7, i[2], i == 4);
      end
      slow <= 1'b0;
      f0 = frames;
      apb(1'b1, tfs_pkg::IDX_PAYLOAD, 32'h5aa5);
      apb(1'b1, tfs_pkg::IDX_CTRL, 32'he840);
      wait_frames(f0 + 1);
      apb(1'b1, tfs_pkg::IDX_PAYLOAD, 32'h1234);
      apb(1'b1, tfs_pkg::IDX_CTRL, 32'he040);
      apb(1'b0, tfs_pkg::IDX_PAYLOAD, 32'h0);
      check(rd, 32'h1234);
      wait_frames(f0 + 3);
      check_frame(2'b01, 4'h1, 4'h0, 16'h5aa5, 1'b0, 1'b0);
      apb(1'b1, tfs_pkg::IDX_CTRL, 32'hc040);
      poll_status(0, 1'b0);
      repeat (400) @(posedge clk);
      check((frames - f0) % BLOCK, 0);
      apb(1'b1, tfs_pkg::IDX_CTRL, 32'h0);
      $display("continuous test done");
      n = rnd() % 9 + 1;
      repeat (n)
      begin
         @(posedge clk);
         crc_err_in <= 1'b1;
         @(posedge clk);
         crc_err_in <= 1'b0;
      end
      apb(1'b0, tfs_pkg::IDX_ERRCNT, 32'h0);
      check(rd, n);
      apb(1'b0, tfs_pkg::IDX_ERRCNT, 32'h0);
      check(rd, 32'h0);
      @(posedge clk);
      crc_err_in <= 1'b1;
      repeat (300) @(posedge clk);
      crc_err_in <= 1'b0;
      apb(1'b0, tfs_pkg::IDX_ERRCNT, 32'h0);
      check(rd, 32'hff);
      $display("error counter test done");
      conclude();
   end
endmodule
